// file: hdl/fault_watch_pkg.sv
// constants and carrier types shared by the fault watch timer
package fault_watch_pkg;

  // ---------------------------------------------------------------
  // register map (printed offsets are indexes, byte address = 4 x)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;                       // axi byte address width
  localparam logic [7:0] CTRL_IDX = 8'h2a;          // watchdog_control_reg index
  localparam logic [7:0] CFG_IDX = 8'h2b;           // watch_cfg_status index
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h7f;          // disabled, count at top
  localparam int ACT_POS = 7;                       // activation_bit
  localparam int TOP_POS = 6;                       // counter_top_bit
  localparam logic [6:0] WRAP_FROM = 7'h40;         // 40h -> 3Fh wrap fires
  localparam int CFG_PIE_POS = 0;                   // periodic_irq_enable, rw
  localparam int CFG_HALTOPT_POS = 1;               // halt_reset_option strap, ro
  localparam int CFG_ALWAYS_POS = 2;                // always-on strap, ro
  localparam int CFG_HALTED_POS = 4;                // in halt (either phase), ro
  localparam int CFG_AHALT_POS = 5;                 // in active-halt, ro
  localparam int CFG_START_POS = 6;                 // start-up delay running, ro
  localparam int CFG_RST_POS = 7;                   // reset pulse under way, ro

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;                 // aclk at 250 MHz
  localparam int DIV_CYC = 16384;                   // clocks per decrement
  localparam int RST_PULSE_NS = 30000;              // reset pulse, 30 us typical
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_SHORT_CYC = 256;             // short start-up delay
  localparam int START_LONG_CYC = 4096;             // long start-up delay

  // ---------------------------------------------------------------
  // bus answers and register select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_CFG = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT_DEC,
    ST_HALT_FROZEN,
    ST_ACTIVE_HALT,
    ST_STARTUP
  } wd_state_t;

  // core events, same clock as aclk
  typedef struct packed {
    logic halt_exec;                                // halt instruction, 1-cycle pulse
    logic periodic_irq;                             // time-base interrupt, level
  } cpu_evt_t;

  // option straps from pins
  typedef struct packed {
    logic always_on;                                // hardware watchdog option
    logic halt_reset;                               // halt_reset_option
    logic long_start;                               // 1: 4096 clocks, 0: 256
  } straps_t;

endpackage : fault_watch_pkg

// file: hdl/fault_watch_timer.sv
// fault watch timer: free-running 7-bit watchdog with axi4-lite registers
`timescale 1ns/100ps

// Summary of operation
// R01: decrement count once per 16384 clocks
// R02: active and 40h to 3Fh wrap: reset pulse
// R03: counter runs always; inactive wrap is harmless
// R04: software refreshes with values C0h to FFh
// R05: low six bits choose the timeout
// R06: disabled after reset; activation only set
// R07: active write with top bit clear resets
// R08: writes never clear the divider
// R09: halt resets if active, option set, no irq
// R10: plain halt: one decrement, then frozen, quiet
// R11: external wake restarts after start-up delay
// R12: reset leaves watchdog disabled unless always-on
// R13: active-halt freezes; irq resumes, reset delays
// R14: always-on option forces the watchdog active
// R15: software should refresh just before halt
// R16: control reg: activation bit 7, count 6:0, 7Fh
// R17: reads show live count; writes load both
module fault_watch_timer #(
  parameter int DIV = fault_watch_pkg::DIV_CYC,          // clocks per decrement
  parameter int RST_CYC = fault_watch_pkg::RST_PULSE_CYC // reset pulse length
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [fault_watch_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fault_watch_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core side
  input wire fault_watch_pkg::cpu_evt_t cpu_evt,
  input wire logic ext_irq_pin,
  input wire fault_watch_pkg::straps_t strap_pins,
  output logic sys_reset_n
);

  // ---------------------------------------------------------------
  // widths and state record
  // ---------------------------------------------------------------
  localparam int PW = $clog2(DIV);                  // divider width
  localparam int RW = $clog2(RST_CYC + 1);          // pulse counter width
  localparam int SW = $clog2(fault_watch_pkg::START_LONG_CYC + 1);

  typedef struct packed {
    fault_watch_pkg::wd_state_t st;                 // run / halt phases
    logic act;                                      // activation_bit, sticky
    logic [6:0] cnt;                                // live count
    logic pie;                                      // periodic_irq_enable copy
    logic [PW-1:0] pre;                             // free divider
    logic reset_n;                                  // reset line, low = reset
    logic [RW-1:0] rst_cnt;                         // pulse length counter
    logic [SW-1:0] start_cnt;                       // start-up delay counter
    logic ext_s1;                                   // pin sync stage 1
    logic ext_s2;                                   // pin sync stage 2
    logic [2:0] strap_s1;                           // strap sync stage 1
    logic [2:0] strap_s2;                           // strap sync stage 2
    logic aw_got;                                   // write address held
    logic [fault_watch_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;                                    // write data held
    logic [7:0] w_data;                             // only byte 0 is stored
    logic w_en;                                     // byte 0 strobe
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_t;

  // reset image: watchdog disabled, count 7Fh, start-up delay pending
  localparam regs_t REGS_RST = '{
    st: fault_watch_pkg::ST_STARTUP,
    cnt: fault_watch_pkg::CTRL_RST[6:0],
    act: fault_watch_pkg::CTRL_RST[fault_watch_pkg::ACT_POS],
    reset_n: 1'b1,
    default: '0
  };

  regs_t r;                                         // registered state
  regs_t n;                                         // next state

  // ---------------------------------------------------------------
  // address decode, shared by read and write paths
  // ---------------------------------------------------------------
  function automatic logic [1:0] reg_sel(input logic [fault_watch_pkg::ADDR_W-1:0] a);
    logic [fault_watch_pkg::ADDR_W-1:0] w;
    w = {a[fault_watch_pkg::ADDR_W-1:2], 2'h0};
    if (w == fault_watch_pkg::CTRL_ADDR)
      return fault_watch_pkg::SEL_CTRL;
    else if (w == fault_watch_pkg::CFG_ADDR)
      return fault_watch_pkg::SEL_CFG;
    else
      return fault_watch_pkg::SEL_NONE;
  endfunction : reg_sel

  // ---------------------------------------------------------------
  // handshake outputs and registered data outputs
  // ---------------------------------------------------------------
  // one write at a time: no new beat until the response is taken
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign sys_reset_n = r.reset_n;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    fault_watch_pkg::straps_t opt;
    logic active;
    logic tick;
    logic fire;
    logic do_wr;
    logic [1:0] wsel;
    logic [1:0] rsel;
    logic [SW-1:0] start_last;
    n = r;
    opt = fault_watch_pkg::straps_t'(r.strap_s2);
    fire = 1'b0;
    // locals start defined so no path can leave one open
    active = 1'b0;
    tick = 1'b0;
    do_wr = 1'b0;
    wsel = fault_watch_pkg::SEL_NONE;
    rsel = fault_watch_pkg::SEL_NONE;
    start_last = '0;

    // pins pass two flops; stage 1 feeds stage 2 only
    n.ext_s1 = ext_irq_pin;
    n.ext_s2 = r.ext_s1;
    n.strap_s1 = strap_pins;
    n.strap_s2 = r.strap_s1;

    // always-on overrides the stored activation bit
    active = r.act || opt.always_on;                                  // [R14]

    // divider runs free; nothing but aresetn clears it
    tick = (r.pre == PW'(DIV - 1));                                   // [R01]
    n.pre = tick ? '0 : r.pre + 1'b1;                                 // [R08]

    start_last = opt.long_start ? SW'(fault_watch_pkg::START_LONG_CYC - 1)
                                : SW'(fault_watch_pkg::START_SHORT_CYC - 1);

    // watchdog sequencing
    case (r.st)
      fault_watch_pkg::ST_RUN:
      begin
        // count keeps going whether or not the watchdog is active
        if (tick)
        begin
          n.cnt = r.cnt - 7'h01;                                      // [R01] [R03]
          // wrap fires only while active
          if (r.cnt == fault_watch_pkg::WRAP_FROM && active)
            fire = 1'b1;                                              // [R02] [R05]
        end
        if (cpu_evt.halt_exec)
        begin
          if (active && opt.halt_reset && !r.pie)
            fire = 1'b1;                                              // [R09]
          else if (r.pie)
            n.st = fault_watch_pkg::ST_ACTIVE_HALT;                   // [R13]
          else
            n.st = fault_watch_pkg::ST_HALT_DEC;                      // [R10]
        end
      end
      fault_watch_pkg::ST_HALT_DEC:
      begin
        // one last decrement, never a reset, then freeze
        if (tick)
        begin
          n.cnt = r.cnt - 7'h01;                                      // [R10]
          n.st = fault_watch_pkg::ST_HALT_FROZEN;
        end
      end
      fault_watch_pkg::ST_HALT_FROZEN:
      begin
        // an external interrupt or a watchdog reset pulse leaves; aresetn covers reset exit
        if (r.ext_s2)
        begin
          n.st = fault_watch_pkg::ST_STARTUP;                         // [R11]
          n.start_cnt = '0;
        end
      end
      fault_watch_pkg::ST_ACTIVE_HALT:
      begin
        // counter frozen; either interrupt resumes at once
        if (r.ext_s2 || cpu_evt.periodic_irq)
          n.st = fault_watch_pkg::ST_RUN;                             // [R13]
      end
      fault_watch_pkg::ST_STARTUP:
      begin
        // oscillator start-up wait, counter frozen
        n.start_cnt = r.start_cnt + 1'b1;
        if (r.start_cnt == start_last)
          n.st = fault_watch_pkg::ST_RUN;                             // [R11] [R13]
      end
      default:
      begin
        n.st = fault_watch_pkg::ST_RUN;
      end
    endcase

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata[7:0];
      n.w_en = s_axi_wstrb[0];
    end
    do_wr = r.aw_got && r.w_got && !r.bvalid;
    wsel = reg_sel(r.aw_addr);
    if (do_wr)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wsel == fault_watch_pkg::SEL_NONE) ? fault_watch_pkg::RESP_SLVERR
                                                    : fault_watch_pkg::RESP_OKAY;
      if (wsel == fault_watch_pkg::SEL_CTRL && r.w_en)
      begin
        // both fields at once; activation can only be set
        n.act = r.act || r.w_data[fault_watch_pkg::ACT_POS];          // [R06] [R17]
        n.cnt = r.w_data[6:0];                                        // [R17] [R05]
        // top bit cleared with watchdog on: reset right away
        if ((active || r.w_data[fault_watch_pkg::ACT_POS]) &&
            !r.w_data[fault_watch_pkg::TOP_POS])
          fire = 1'b1;                                                // [R07]
      end
      else if (wsel == fault_watch_pkg::SEL_CFG && r.w_en)
      begin
        n.pie = r.w_data[fault_watch_pkg::CFG_PIE_POS];
      end
    end
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;

    // read channel: answer registered one cycle after the address
    rsel = reg_sel(s_axi_araddr);
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = fault_watch_pkg::RESP_OKAY;
      if (rsel == fault_watch_pkg::SEL_CTRL)
        n.rdata = {24'h000000, r.act, r.cnt};                         // [R17] [R16]
      else if (rsel == fault_watch_pkg::SEL_CFG)
        n.rdata = {24'h000000, !r.reset_n,
                   r.st == fault_watch_pkg::ST_STARTUP,
                   r.st == fault_watch_pkg::ST_ACTIVE_HALT,
                   r.st == fault_watch_pkg::ST_HALT_DEC ||
                   r.st == fault_watch_pkg::ST_HALT_FROZEN,
                   1'b0, opt.always_on, opt.halt_reset, r.pie};
      else
      begin
        n.rdata = 32'h00000000;
        n.rresp = fault_watch_pkg::RESP_SLVERR;
      end
    end
    if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;

    // reset pulse; a second trigger during the pulse is ignored
    if (!r.reset_n)
    begin
      n.rst_cnt = r.rst_cnt + 1'b1;
      if (r.rst_cnt == RW'(RST_CYC - 1))
        n.reset_n = 1'b1;                                             // [R02]
    end
    else if (fire)
    begin
      n.reset_n = 1'b0;                                               // [R02]
      n.rst_cnt = '0;
      // the reset it causes leaves the watchdog disabled unless always-on
      n.act = fault_watch_pkg::CTRL_RST[fault_watch_pkg::ACT_POS];    // [R06] [R12]
      n.cnt = fault_watch_pkg::CTRL_RST[6:0];
      n.st = fault_watch_pkg::ST_RUN;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // system reset always lands disabled with 7Fh; always-on is a strap
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= REGS_RST;                                                  // [R06] [R12] [R16]
    else
      r <= n;
  end

endmodule : fault_watch_timer

// file: tb/fault_watch_monitor.sv
// assertion checker for the fault watch timer ports
`timescale 1ns/100ps
module fault_watch_monitor #(
  parameter int RST_CYC = fault_watch_pkg::RST_PULSE_CYC // reset pulse length in clocks
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sys_reset_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] low_cnt_r; // clocks the reset line has been low
  logic wr_go; // address and data taken at one edge
  logic ctrl_hit; // write aimed at the control register
  logic rd_bad; // read aimed at no register
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ctrl_hit = s_axi_awaddr[11:2] == fault_watch_pkg::CTRL_ADDR[11:2];
  assign rd_bad = s_axi_araddr[11:2] != fault_watch_pkg::CTRL_ADDR[11:2]
    && s_axi_araddr[11:2] != fault_watch_pkg::CFG_ADDR[11:2];
  // counter of low cycles, cleared whenever the line is high
  always_ff @(posedge aclk)
  begin
    if (!aresetn || sys_reset_n)
      low_cnt_r <= 16'h0;
    else
      low_cnt_r <= low_cnt_r + 16'h1;
  end
  property p_wr_ans; wr_go |-> ##2 s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_w_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_refuse: assert property (p_w_refuse) else $error("write taken while answering");
  property p_r_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_refuse: assert property (p_r_refuse) else $error("read taken while answering");
  property p_unmapped; s_axi_arvalid && s_axi_arready && rd_bad
    |=> s_axi_rresp == fault_watch_pkg::RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_pulse_len; $rose(sys_reset_n) |-> low_cnt_r == 16'(RST_CYC); endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
  property p_soft_rst; wr_go && ctrl_hit && s_axi_wstrb[0] && s_axi_wdata[7]
    && !s_axi_wdata[6] && sys_reset_n |-> ##2 !sys_reset_n; endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset missing");
  c_wr: cover property (wr_go);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_pulse: cover property ($fell(sys_reset_n));
endmodule : fault_watch_monitor

bind fault_watch_timer fault_watch_monitor #(.RST_CYC(RST_CYC)) i_fault_watch_monitor (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .sys_reset_n);

// file: tb/fault_watch_timer_tb.sv
// self-checking bench for the fault watch timer
`timescale 1ns/100ps
module fault_watch_timer_tb;
  localparam logic [11:0] CA = fault_watch_pkg::CTRL_ADDR;
  localparam logic [11:0] GA = fault_watch_pkg::CFG_ADDR;
  localparam logic [1:0] OK = fault_watch_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = fault_watch_pkg::RESP_SLVERR;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, sys_reset_n, ext_irq_pin, hi_r;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v0, v1;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  fault_watch_pkg::cpu_evt_t cpu_evt;
  fault_watch_pkg::straps_t strap_pins;
  int num_errors, n_checks, falls;
  // short divider and pulse keep the run brief
  fault_watch_timer #(.DIV(16), .RST_CYC(8)) i_fault_watch_timer (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_evt,
    .ext_irq_pin, .strap_pins, .sys_reset_n);
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // count falling edges of the reset line, sampled on the clock
  always @(posedge aclk)
  begin
    if (hi_r === 1'b1 && sys_reset_n === 1'b0)
      falls <= falls + 1;
    hi_r <= sys_reset_n;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // write one byte; address and data released as each is taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  // read; the address is taken one edge before the data lands
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    // rready stays up, so the answer is taken at the edge that shows rvalid; each read drives it high again
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  // two reads exactly 64 clocks apart: four divider periods
  task automatic span(output logic [31:0] a, output logic [31:0] b);
    rd(CA, a, rs);
    cyc(62);
    rd(CA, b, rs);
  endtask : span
  task automatic halt;
    cpu_evt.halt_exec <= 1'b1;
    @(posedge aclk);
    cpu_evt.halt_exec <= 1'b0;
  endtask : halt
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // watchdog: the whole sequence needs about 1600 clocks
  initial
  begin
    #80000;
    num_errors++;
    final_report();
  end
  initial
  begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 56'h0;
    s_axi_wstrb <= 4'hf;
    {cpu_evt, ext_irq_pin, strap_pins} <= 6'h0;
    cyc(6);
    aresetn <= 1'b1;
    cyc(1);
    rd(CA, v0, rs);
    chk(v0, 32'h7f);
    rd(12'h000, v0, rs);
    chk({v0[29:0], rs}, {30'h0, ERR});
    wr(12'h000, 8'hff, ERR);
    cyc(300); // start-up delay over
    span(v0, v1);
    chk(v0 - v1, 32'h4);
    wr(CA, 8'h41, OK);
    cyc(100);
    rd(CA, v0, rs);
    chk({v0[7:6], 30'(falls)}, 32'h0);
    wr(CA, 8'hff, OK);
    rd(CA, v0, rs);
    chk({31'h0, v0[7]}, 32'h1);
    wr(CA, 8'h7f, OK);
    rd(CA, v0, rs);
    chk({30'h0, v0[7:6]}, 32'h3);
    wr(CA, 8'hc2, OK); // third decrement wraps
    cyc(20);
    chk(falls, 32'h0);
    cyc(40);
    chk(falls, 32'h1);
    cyc(10);
    rd(CA, v0, rs);
    chk({31'h0, v0[7]}, 32'h0);
    wr(CA, 8'hbf, OK);
    cyc(2);
    chk(falls, 32'h2);
    cyc(12);
    strap_pins.always_on <= 1'b1;
    cyc(4);
    wr(CA, 8'h3f, OK);
    cyc(2);
    chk(falls, 32'h3);
    strap_pins.always_on <= 1'b0;
    strap_pins.halt_reset <= 1'b1;
    cyc(12);
    wr(CA, 8'hff, OK);
    halt();
    cyc(3);
    chk(falls, 32'h4);
    strap_pins.halt_reset <= 1'b0;
    cyc(12);
    wr(GA, 8'h01, OK);
    wr(CA, 8'hff, OK);
    halt(); // periodic enable set: active-halt
    cyc(2);
    rd(GA, v0, rs);
    chk({31'h0, v0[5]}, 32'h1);
    span(v0, v1);
    chk(v1, v0);
    cpu_evt.periodic_irq <= 1'b1;
    cyc(1);
    cpu_evt.periodic_irq <= 1'b0;
    cyc(2);
    span(v0, v1);
    chk(v0 - v1, 32'h4);
    wr(GA, 8'h00, OK);
    wr(CA, 8'hff, OK);
    halt(); // plain halt: one decrement then frozen
    cyc(40);
    span(v0, v1);
    chk({31'h0, 7'h7f - v0[6:0] inside {7'h1, 7'h2}}, 32'h1);
    chk(v1, v0);
    chk(falls, 32'h4);
    ext_irq_pin <= 1'b1;
    cyc(4);
    ext_irq_pin <= 1'b0;
    cyc(100);
    rd(GA, v0, rs);
    chk({31'h0, v0[6]}, 32'h1);
    cyc(200);
    span(v0, v1);
    chk(v0 - v1, 32'h4);
    // second reset in mid-run, long start-up strap this time
    strap_pins.long_start <= 1'b1;
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(1);
    rd(CA, v0, rs);
    chk(v0, 32'h7f);
    cyc(300);
    rd(GA, v0, rs);
    chk({31'h0, v0[6]}, 32'h1);
    final_report();
  end
endmodule : fault_watch_timer_tb
